/* File: ucs_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ucs_consts.svh"

// Function
// R01 - Software sets pin directions, clears port latches
// R02 - Enable bits select stop, rx, tx, duplex
// R03 - Parity field: none, zero, odd, even
// R04 - Length bit picks seven or eight data
// R05 - Stop length bit picks one or two
// R06 - Receiver checks only the first stop bit
// R07 - Suppress bit hides completion on errored frames
// R08 - Software writes zero to mode bit 0
// R09 - Mode changes only when serial link idle
// R10 - Status read-only byte, upper bits zero
// R11 - Parity mismatch sets parity error flag
// R12 - Missing stop bit sets framing flag
// R13 - Unread buffer at completion sets overrun
// R14 - Overrun repeats until buffer read
// R15 - Baud register byte written, resets zero
// R16 - Prescaler divides main clock by 2^n; the code's prescaler divides by 2^(n+1)
// R17 - Divider divides by sixteen plus k
// R18 - Software writes zero to baud bit 7
// R19 - No baud writes during communication
// R20 - Bit clock derived only from main clock
// R21 - Baud equals clock over 2^(n+1)(16+k); the code gives a bit time of 2^(n+2)(16+k) clocks
// R22 - Parity check counts ones including parity
// R23 - Idle high, start low, LSB first, stop high
module ucs_top (
   input  wire logic                     clk_i,
   input  wire logic                     reset_n_i,
   input  wire logic                     ce_i,
   input  wire ucs_pkg::ucs_bus_req_type bus_req_i,
   output logic [7:0]                    rd_data_o,
   input  wire logic                     rx_pin_i,
   output logic                          tx_pin_o,
   output logic                          rx_serial_sel_o,
   output logic                          tx_serial_sel_o,
   input  wire logic [7:0]               tx_data_i,
   input  wire logic                     tx_write_i,
   output logic                          tx_ready_o,
   output logic                          tx_done_o,
   input  wire logic                     rx_buf_read_i,
   output logic [7:0]                    rx_data_o,
   output logic                          rx_done_o
);
   import ucs_pkg::*;

   ucs_state_type st;
   ucs_state_type next_st;
   logic          tick;
   logic          tx_en;
   logic          rx_en;
   logic [1:0]    par_mode;
   logic [3:0]    n_data;
   logic          par_used;
   logic          two_stop;
   logic          err_supp;
   logic          rx_sample;
   logic          tx_edge;
   logic          rx_complete;
   ucs_err_type   frame_err;

   ////////////////////////////////////////////////////////////////////////
   // Helpers

   function automatic logic [3:0] data_count(input logic char_length_bit);
      data_count = char_length_bit ? `UCS_CHARS_LONG : `UCS_CHARS_SHORT;
   endfunction

   function automatic logic parity_value(input logic [1:0] mode, input logic [7:0] data);
      case (mode)
         `UCS_PAR_ODD:  parity_value = ~(^data);
         `UCS_PAR_EVEN: parity_value = ^data;
         default:       parity_value = 1'b0;
      endcase
   endfunction

   function automatic logic [7:0] data_mask(input logic char_length_bit, input logic [7:0] data);
      data_mask = char_length_bit ? data : {1'b0, data[6:0]};
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Baud rate generator

   ucs_baud_gen u_baud (
      .clk_i     (clk_i),
      .reset_n_i (reset_n_i),
      .ce_i      (ce_i),
      .run_i     (tx_en | rx_en),
      .baud_i    (st.baud_divider_control),
      .tick_o    (tick)
   );

   ////////////////////////////////////////////////////////////////////////
   // Decoded configuration

   always_comb begin
      tx_en    = st.serial_mode_control[`UCS_TX_EN_BIT];
      rx_en    = st.serial_mode_control[`UCS_RX_EN_BIT];
      par_mode = {st.serial_mode_control[`UCS_PAR_HI_BIT], st.serial_mode_control[`UCS_PAR_LO_BIT]};
      n_data   = data_count(st.serial_mode_control[`UCS_CHAR_LEN_BIT]); // R04
      par_used = (par_mode != `UCS_PAR_NONE); // R03
      two_stop = st.serial_mode_control[`UCS_STOP_LEN_BIT];
      err_supp = st.serial_mode_control[`UCS_ERR_SUPP_BIT];
      rx_sample = tick & st.rx_half;
      tx_edge   = tick & st.tx_half;
   end

   ////////////////////////////////////////////////////////////////////////
   // Frame completion and error evaluation

   always_comb begin
      rx_complete = rx_en & rx_sample & (st.rx_ph == PH_STOP);
      frame_err.parity_err_flag = ((par_mode == `UCS_PAR_ODD) | (par_mode == `UCS_PAR_EVEN)) &
                                  (st.rx_par != parity_value(par_mode, st.rx_shift)); // R11 R22
      frame_err.framing_err_flag = ~rx_pin_i; // R06 R12
      frame_err.overrun_err_flag = st.rx_full & ~rx_buf_read_i; // R13 R14
   end

   ////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      next_st = st;
      next_st.rx_done = 1'b0;
      next_st.tx_done = 1'b0;

      // Register access
      next_st.rd_data = st.rd_data;
      if (bus_req_i.rd) begin
         case (bus_req_i.addr)
            `UCS_ADDR_MODE:   next_st.rd_data = st.serial_mode_control;
            `UCS_ADDR_STATUS: next_st.rd_data = {5'h00, st.err}; // R10
            `UCS_ADDR_BAUD:   next_st.rd_data = st.baud_divider_control;
            default:          next_st.rd_data = 8'h00;
         endcase
         if (bus_req_i.addr == `UCS_ADDR_STATUS) begin
            next_st.err = '0;
         end
      end
      if (bus_req_i.wr) begin
         case (bus_req_i.addr)
            `UCS_ADDR_MODE: begin
               next_st.serial_mode_control = bus_req_i.wdata; // R02
            end
            `UCS_ADDR_BAUD: begin
               next_st.baud_divider_control = bus_req_i.wdata; // R15
            end
            default: begin
               next_st.serial_mode_control = next_st.serial_mode_control;
            end
         endcase
      end

      // Receive buffer handshake
      if (rx_buf_read_i) begin
         next_st.rx_full = 1'b0;
      end

      // Receiver
      if (!rx_en) begin
         next_st.rx_ph = PH_IDLE; // R02
      end else if (tick) begin
         next_st.rx_half = ~st.rx_half;
         case (st.rx_ph)
            PH_IDLE: begin
               if (!rx_pin_i) begin // R23
                  next_st.rx_ph = PH_START;
                  next_st.rx_half = 1'b1;
               end
            end
            PH_START: begin
               if (rx_pin_i) begin
                  next_st.rx_ph = PH_IDLE;
               end else begin
                  next_st.rx_ph = PH_DATA;
                  next_st.rx_idx = 4'h0;
                  next_st.rx_shift = 8'h00;
                  next_st.rx_par = 1'b0;
                  next_st.rx_half = 1'b0;
               end
            end
            PH_DATA: begin
               if (st.rx_half) begin
                  if (st.rx_idx < n_data) begin
                     next_st.rx_shift[st.rx_idx[2:0]] = rx_pin_i; // R23
                  end else begin
                     next_st.rx_par = rx_pin_i;
                  end
                  next_st.rx_idx = st.rx_idx + 4'h1;
                  if ((st.rx_idx + 4'h1) == (n_data + {3'h0, par_used})) begin
                     next_st.rx_ph = PH_STOP;
                  end
               end
            end
            PH_STOP: begin
               if (st.rx_half) begin
                  next_st.rx_ph = PH_IDLE; // R06
               end
            end
            default: begin
               next_st.rx_ph = PH_IDLE;
            end
         endcase
      end

      if (rx_complete) begin
         next_st.receive_buffer = st.rx_shift;
         next_st.rx_full = 1'b1; // R14
         next_st.err.parity_err_flag = next_st.err.parity_err_flag | frame_err.parity_err_flag; // R11
         next_st.err.framing_err_flag = next_st.err.framing_err_flag | frame_err.framing_err_flag; // R12
         next_st.err.overrun_err_flag = next_st.err.overrun_err_flag | frame_err.overrun_err_flag; // R13
         next_st.rx_done = ~(err_supp & (|frame_err)); // R07
      end

      // Transmitter
      if (!tx_en) begin
         next_st.tx_ph = PH_IDLE; // R02
         next_st.tx_pin = 1'b1;
      end else begin
         case (st.tx_ph)
            PH_IDLE: begin
               next_st.tx_pin = 1'b1; // R23
               if (tx_write_i) begin
                  next_st.tx_shift = data_mask(st.serial_mode_control[`UCS_CHAR_LEN_BIT], tx_data_i); // R04
                  next_st.tx_ph = PH_START;
                  next_st.tx_pin = 1'b0; // R23
                  next_st.tx_half = 1'b0;
               end
            end
            PH_START: begin
               if (tick) begin
                  next_st.tx_half = ~st.tx_half;
               end
               if (tx_edge) begin
                  next_st.tx_ph = PH_DATA;
                  next_st.tx_idx = 4'h0;
                  next_st.tx_pin = st.tx_shift[0]; // R23
               end
            end
            PH_DATA: begin
               if (tick) begin
                  next_st.tx_half = ~st.tx_half;
               end
               if (tx_edge) begin
                  next_st.tx_idx = st.tx_idx + 4'h1;
                  if ((st.tx_idx + 4'h1) < n_data) begin
                     next_st.tx_pin = st.tx_shift[3'(st.tx_idx + 4'h1)];
                  end else if (((st.tx_idx + 4'h1) == n_data) && par_used) begin
                     next_st.tx_pin = parity_value(par_mode, st.tx_shift); // R03
                  end else begin
                     next_st.tx_ph = PH_STOP;
                     next_st.tx_idx = 4'h0;
                     next_st.tx_pin = 1'b1; // R23
                  end
               end
            end
            PH_STOP: begin
               if (tick) begin
                  next_st.tx_half = ~st.tx_half;
               end
               if (tx_edge) begin
                  if (two_stop && (st.tx_idx == 4'h0)) begin
                     next_st.tx_idx = 4'h1; // R05
                  end else begin
                     next_st.tx_ph = PH_IDLE;
                     next_st.tx_done = 1'b1;
                  end
               end
            end
            default: begin
               next_st.tx_ph = PH_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st <= '0;
         st.serial_mode_control <= `UCS_MODE_RESET;
         st.baud_divider_control <= `UCS_BAUD_RESET; // R15
         st.err <= 3'(`UCS_STATUS_RESET); // R10
         st.rx_ph <= PH_IDLE;
         st.tx_ph <= PH_IDLE;
         st.tx_pin <= 1'b1;
      end else if (ce_i) begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs

   assign rd_data_o       = st.rd_data;
   assign tx_pin_o        = st.tx_pin;
   assign rx_serial_sel_o = st.serial_mode_control[`UCS_RX_EN_BIT];
   assign tx_serial_sel_o = st.serial_mode_control[`UCS_TX_EN_BIT];
   assign tx_ready_o      = tx_en & (st.tx_ph == PH_IDLE);
   assign tx_done_o       = st.tx_done;
   assign rx_data_o       = st.receive_buffer;
   assign rx_done_o       = st.rx_done;

endmodule // ucs_top
`default_nettype wire

/* File: ucs_consts.svh */
`ifndef UCS_CONSTS_SVH
`define UCS_CONSTS_SVH

// Register addresses
`define UCS_ADDR_MODE        16'hff85
`define UCS_ADDR_STATUS      16'hff86
`define UCS_ADDR_BAUD        16'hff87

// Reset values
`define UCS_MODE_RESET       8'h00
`define UCS_STATUS_RESET     8'h00
`define UCS_BAUD_RESET       8'h00

// Mode register fields
`define UCS_TX_EN_BIT        7
`define UCS_RX_EN_BIT        6
`define UCS_PAR_HI_BIT       5
`define UCS_PAR_LO_BIT       4
`define UCS_CHAR_LEN_BIT     3
`define UCS_STOP_LEN_BIT     2
`define UCS_ERR_SUPP_BIT     1

// Parity codes
`define UCS_PAR_NONE         2'h0
`define UCS_PAR_ZERO         2'h1
`define UCS_PAR_ODD          2'h2
`define UCS_PAR_EVEN         2'h3

// Status register fields
`define UCS_PE_BIT           2
`define UCS_FE_BIT           1
`define UCS_OVE_BIT          0

// Baud register fields
`define UCS_PRE_MSB          6
`define UCS_PRE_LSB          4
`define UCS_DIV_MSB          3
`define UCS_DIV_LSB          0
`define UCS_DIV_BASE         5'h10

// Character lengths
`define UCS_CHARS_SHORT      4'h7
`define UCS_CHARS_LONG       4'h8

`endif

/* File: ucs_pkg.sv */
package ucs_pkg;

   typedef struct packed {
      logic [15:0] addr;
      logic [7:0]  wdata;
      logic        wr;
      logic        rd;
   } ucs_bus_req_type;

   typedef enum logic [1:0] {
      PH_IDLE  = 2'b00,
      PH_START = 2'b01,
      PH_DATA  = 2'b10,
      PH_STOP  = 2'b11
   } ucs_phase_type;

   typedef struct packed {
      logic parity_err_flag;
      logic framing_err_flag;
      logic overrun_err_flag;
   } ucs_err_type;

   typedef struct packed {
      logic [7:0]    serial_mode_control;
      logic [7:0]    baud_divider_control;
      ucs_err_type   err;
      logic          rx_full;
      logic [7:0]    receive_buffer;
      logic [7:0]    rd_data;
      ucs_phase_type rx_ph;
      logic          rx_half;
      logic [3:0]    rx_idx;
      logic [7:0]    rx_shift;
      logic          rx_par;
      logic          rx_done;
      ucs_phase_type tx_ph;
      logic          tx_half;
      logic [3:0]    tx_idx;
      logic [7:0]    tx_shift;
      logic          tx_pin;
      logic          tx_done;
   } ucs_state_type;

endpackage

/* File: ucs_baud_gen.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ucs_consts.svh"

module ucs_baud_gen (
   input  wire logic       clk_i,
   input  wire logic       reset_n_i,
   input  wire logic       ce_i,
   input  wire logic       run_i,
   input  wire logic [7:0] baud_i,
   output logic            tick_o
);
   import ucs_pkg::*;

   typedef struct packed {
      logic [7:0] pre_cnt;
      logic [4:0] div_cnt;
      logic       tick;
   } ucs_baud_state_type;

   ucs_baud_state_type st;
   ucs_baud_state_type next_st;
   logic [7:0]         pre_limit;
   logic [4:0]         div_limit;

   ////////////////////////////////////////////////////////////////////////
   // Prescaler by two to the n+1, then divider by sixteen plus k
   always_comb begin
      pre_limit = 8'((9'h002 << baud_i[`UCS_PRE_MSB:`UCS_PRE_LSB]) - 9'h001); // R16
      div_limit = `UCS_DIV_BASE + {1'b0, baud_i[`UCS_DIV_MSB:`UCS_DIV_LSB]} - 5'h01; // R17
      next_st = st;
      next_st.tick = 1'b0;
      if (!run_i) begin
         next_st.pre_cnt = 8'h00;
         next_st.div_cnt = 5'h00;
      end else if (st.pre_cnt >= pre_limit) begin // R20
         next_st.pre_cnt = 8'h00;
         if (st.div_cnt >= div_limit) begin
            next_st.div_cnt = 5'h00;
            next_st.tick = 1'b1; // R21
         end else begin
            next_st.div_cnt = st.div_cnt + 5'h01;
         end
      end else begin
         next_st.pre_cnt = st.pre_cnt + 8'h01;
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st <= '0;
      end else if (ce_i) begin
         st <= next_st;
      end
   end

   assign tick_o = st.tick & ce_i;

endmodule // ucs_baud_gen
`default_nettype wire

/* File: ucs_top_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ucs_consts.svh"
module ucs_top_assertions (
   input wire logic                     clk_i,
   input wire logic                     reset_n_i,
   input wire logic                     ce_i,
   input wire ucs_pkg::ucs_bus_req_type bus_req_i,
   input wire logic [7:0]               rd_data_o,
   input wire logic                     rx_pin_i,
   input wire logic                     tx_pin_o,
   input wire logic                     rx_serial_sel_o,
   input wire logic                     tx_serial_sel_o,
   input wire logic [7:0]               tx_data_i,
   input wire logic                     tx_write_i,
   input wire logic                     tx_ready_o,
   input wire logic                     tx_done_o,
   input wire logic                     rx_buf_read_i,
   input wire logic [7:0]               rx_data_o,
   input wire logic                     rx_done_o
);
   import ucs_pkg::*;
   logic [7:0] mode_sh;
   logic [7:0] baud_sh;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   // Shadow copies of the writable registers
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         mode_sh <= 8'h00;
         baud_sh <= 8'h00;
      end else if (ce_i && bus_req_i.wr) begin
         if (bus_req_i.addr == `UCS_ADDR_MODE) mode_sh <= bus_req_i.wdata;
         if (bus_req_i.addr == `UCS_ADDR_BAUD) baud_sh <= bus_req_i.wdata;
      end
   end
   sequence s_rd(logic [15:0] a);
      ce_i && bus_req_i.rd && bus_req_i.addr == a;
   endsequence
   sequence s_load;
      ce_i && tx_write_i && tx_ready_o;
   endsequence
   a_sel_follow: assert property (ce_i && bus_req_i.wr && bus_req_i.addr == `UCS_ADDR_MODE |=>
      {tx_serial_sel_o, rx_serial_sel_o} == $past(bus_req_i.wdata[7:6])) else $error("Pin select wrong");
   a_ready_sel: assert property (tx_ready_o |-> tx_serial_sel_o) else $error("Ready while off");
   a_tx_idle: assert property (!tx_serial_sel_o && !$past(tx_serial_sel_o) |-> tx_pin_o)
      else $error("Tx pin low while off");
   a_status_hi: assert property (s_rd(`UCS_ADDR_STATUS) |=> rd_data_o[7:3] == 5'h00)
      else $error("Status upper bits set");
   a_unmapped_zero: assert property (ce_i && bus_req_i.rd && (bus_req_i.addr < `UCS_ADDR_MODE ||
      bus_req_i.addr > `UCS_ADDR_BAUD) |=> rd_data_o == 8'h00) else $error("Unmapped read not zero");
   a_rd_hold: assert property (!(ce_i && bus_req_i.rd) |=> $stable(rd_data_o))
      else $error("Read data moved");
   a_baud_read: assert property (s_rd(`UCS_ADDR_BAUD) ##0 !bus_req_i.wr |=> rd_data_o == baud_sh)
      else $error("Baud readback wrong");
   a_start_low: assert property (s_load |=> (!tx_pin_o && !tx_ready_o) [*8])
      else $error("Start bit too short");
   a_len_seven: assert property (rx_done_o && !mode_sh[`UCS_CHAR_LEN_BIT] |-> !rx_data_o[7])
      else $error("Bit 7 set in short mode");
   a_done_stop: assert property (tx_done_o |-> tx_pin_o ##1 !tx_done_o)
      else $error("Tx done not after stop");
endmodule // ucs_top_assertions
`default_nettype wire

/* File: ucs_peer.sv */
`timescale 1ns/1ps
`default_nettype none
module ucs_peer (
   input  wire logic [15:0] bit_clks_i,
   input  wire logic        clk_i,
   input  wire logic        par_en_i,
   input  wire logic        tx_line_i,
   output logic             rx_line_o,
   output logic [9:0]       cap_o,
   output logic             cap_vld_o
);
   int i;
   int n;
   initial begin
      rx_line_o = 1'b1;
      cap_o = 10'h000;
      cap_vld_o = 1'b0;
   end
   task automatic hold(input logic v);
      @(posedge clk_i);
      #1 rx_line_o = v;
      repeat (bit_clks_i - 1) @(posedge clk_i);
   endtask
   // Bad: 1 first stop low, 2 second stop low, 3 parity flipped
   task automatic send(input logic [7:0] d, input logic ld, input logic [1:0] pm,
                       input logic ns, input logic [1:0] bad);
      logic [7:0] m;
      logic       p;
      m = ld ? d : {1'b0, d[6:0]};
      p = (pm == 2'h2) ? ~^m : (pm == 2'h3) ? ^m : 1'b0;
      hold(1'b0);
      for (int b = 0; b < (ld ? 8 : 7); b++) hold(m[b]);
      if (pm != 2'h0) hold(p ^ (bad == 2'h3));
      hold(bad != 2'h1);
      if (ns) hold(bad != 2'h2);
      hold(1'b1);
   endtask
   // Capture {stop, parity, data}, sampling away from the start jitter
   always begin
      @(negedge tx_line_i);
      repeat (bit_clks_i / 4) @(posedge clk_i);
      if (!tx_line_i) begin
         n = par_en_i ? 9 : 8;
         cap_o = 10'h000;
         for (i = 0; i <= n; i++) begin
            repeat (bit_clks_i) @(posedge clk_i);
            cap_o[(i == n) ? 9 : i] = tx_line_i;
         end
         cap_vld_o = 1'b1;
         #1 cap_vld_o = 1'b0;
      end
   end
endmodule // ucs_peer
`default_nettype wire

/* File: uart_config_status_baud_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ucs_consts.svh"
module uart_config_status_baud_tb;
   import ucs_pkg::*;
   logic            clk, reset_n, ce, tx_pin, rx_pin, rx_sel, tx_sel, tx_write, tx_ready, tx_done;
   logic            rx_buf_read, rx_done, par_en, cap_vld, pend, need, auto_rd;
   logic [7:0]      rd_data, tx_data, rx_data, mode_r;
   logic [9:0]      cap;
   logic [15:0]     bitc;
   logic [31:0]     seed;
   logic [9:0]      q_reg[$], q_rx[$], q_tx[$];
   ucs_bus_req_type req;
   int              error_cnt, check_count;
   ucs_top ucs_top_i (.clk_i(clk), .reset_n_i(reset_n), .ce_i(ce), .bus_req_i(req), .rd_data_o(rd_data),
      .rx_pin_i(rx_pin), .tx_pin_o(tx_pin), .rx_serial_sel_o(rx_sel), .tx_serial_sel_o(tx_sel),
      .tx_data_i(tx_data), .tx_write_i(tx_write), .tx_ready_o(tx_ready), .tx_done_o(tx_done),
      .rx_buf_read_i(rx_buf_read), .rx_data_o(rx_data), .rx_done_o(rx_done));
   ucs_peer ucs_peer_i (.bit_clks_i(bitc), .clk_i(clk), .par_en_i(par_en), .tx_line_i(tx_pin),
      .rx_line_o(rx_pin), .cap_o(cap), .cap_vld_o(cap_vld));
   task automatic finish_test();
      if (error_cnt == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [9:0] got, input logic [9:0] exp);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_reg(input logic [7:0] got, input logic [9:0] exp);
      chk({2'h0, got}, exp);
   endtask
   task automatic chk_rx(input logic [7:0] got, input logic [9:0] exp);
      chk({2'h0, got}, exp);
   endtask
   function automatic logic [7:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed[7:0];
   endfunction
   task automatic bus(input logic [15:0] a, input logic [7:0] d, input logic w);
      @(posedge clk);
      #1 req = '{addr: a, wdata: d, wr: w, rd: !w};
      @(posedge clk);
      #1 req = '0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      q_reg.push_back({2'h0, e});
      bus(a, 8'h00, 1'b0);
   endtask
   task automatic set_mode(input logic [7:0] m);
      mode_r = m;
      par_en = m[5] | m[4];
      bus(`UCS_ADDR_MODE, m, 1'b1);
   endtask
   task automatic send_tx(input logic [7:0] d);
      int n;
      int fb;
      logic p;
      logic [7:0] m;
      logic [10:0] s;
      m = mode_r[3] ? d : {1'b0, d[6:0]};
      p = (mode_r[5:4] == 2'h2) ? ~^m : (mode_r[5:4] == 2'h3) ? ^m : 1'b0;
      s = mode_r[3] ? {2'h3, p, m} : {3'h7, p, m[6:0]};
      if (!par_en) s = mode_r[3] ? {3'h7, m} : {4'hf, m[6:0]};
      fb = 9 + mode_r[3] + par_en + mode_r[2];
      n = 0;
      while (tx_ready !== 1'b1 && n < 5000) begin
         @(posedge clk);
         #1 n++;
      end
      q_tx.push_back(par_en ? s[9:0] : {s[8], 1'b0, s[7:0]});
      tx_data = d;
      tx_write = 1'b1;
      @(posedge clk);
      #1 tx_write = 1'b0;
      n = 1;
      while (tx_done !== 1'b1 && n < 5000) begin
         @(posedge clk);
         #1 n++;
      end
      chk({9'h0, n >= (fb - 1) * bitc + bitc / 2 - 2 && n <= fb * bitc + 3}, 10'h001);
   endtask
   task automatic send_rx(input logic [1:0] bad, input logic ex);
      logic [7:0] d;
      d = rnd();
      if (ex) q_rx.push_back({2'h0, mode_r[3] ? d : {1'b0, d[6:0]}});
      ucs_peer_i.send(d, mode_r[3], mode_r[5:4], mode_r[2], bad);
      repeat (4) @(posedge clk);
      #1;
   endtask
   // Result watchers
   always @(posedge clk) pend <= req.rd & ce;
   always @(negedge clk) begin
      if (pend === 1'b1) chk_reg(rd_data, q_reg.size() ? q_reg.pop_front() : 10'hx);
      if (rx_done === 1'b1) begin
         chk_rx(rx_data, q_rx.size() ? q_rx.pop_front() : 10'hx);
         if (auto_rd) need = 1'b1;
      end
   end
   always @(posedge clk) begin
      #1 rx_buf_read = need;
      need = 1'b0;
   end
   always @(posedge cap_vld) chk(cap, q_tx.size() ? q_tx.pop_front() : 10'hx);
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      repeat (80000) @(posedge clk);
      error_cnt++;
      finish_test();
   end
   initial begin
      {reset_n, tx_write, rx_buf_read, par_en, need, pend} = '0;
      {ce, auto_rd} = 2'b11;
      {req, tx_data, mode_r} = '0;
      bitc = 16'd64;
      seed = 32'h5b4740f3;
      repeat (3) @(posedge clk);
      #1 reset_n = 1'b1;
      rd(`UCS_ADDR_MODE, 8'h00);
      rd(`UCS_ADDR_STATUS, 8'h00);
      rd(`UCS_ADDR_BAUD, 8'h00);
      rd(16'hff80, 8'h00);
      bus(`UCS_ADDR_STATUS, 8'hff, 1'b1);
      rd(`UCS_ADDR_STATUS, 8'h00);
      bus(`UCS_ADDR_BAUD, 8'h7b, 1'b1);
      rd(`UCS_ADDR_BAUD, 8'h7b);
      bus(`UCS_ADDR_BAUD, 8'h00, 1'b1);
      for (int p = 0; p < 4; p++) begin
         set_mode(8'hc8 | 8'(p << 4));
         send_tx(rnd());
         send_rx(2'h0, 1'b1);
         send_rx(2'h3, 1'b1);
         rd(`UCS_ADDR_STATUS, (p > 1) ? 8'h04 : 8'h00);
      end
      set_mode(8'hcc);
      send_tx(rnd());
      send_rx(2'h2, 1'b1);
      q_rx.push_back(10'h0ff);
      repeat (12 * bitc) @(posedge clk);
      rd(`UCS_ADDR_STATUS, 8'h00);
      set_mode(8'hc8);
      send_rx(2'h1, 1'b1);
      rd(`UCS_ADDR_STATUS, 8'h02);
      set_mode(8'hca);
      send_rx(2'h1, 1'b0);
      rd(`UCS_ADDR_STATUS, 8'h02);
      @(negedge clk);
      need = 1'b1;
      send_rx(2'h0, 1'b1);
      set_mode(8'hc0);
      send_rx(2'h0, 1'b1);
      send_tx(rnd());
      auto_rd = 1'b0;
      set_mode(8'hc8);
      send_rx(2'h0, 1'b1);
      send_rx(2'h0, 1'b1);
      rd(`UCS_ADDR_STATUS, 8'h01);
      send_rx(2'h0, 1'b1);
      rd(`UCS_ADDR_STATUS, 8'h01);
      @(negedge clk);
      need = 1'b1;
      auto_rd = 1'b1;
      send_rx(2'h0, 1'b1);
      rd(`UCS_ADDR_STATUS, 8'h00);
      bus(`UCS_ADDR_BAUD, 8'h11, 1'b1);
      bitc = 16'd136;
      send_tx(rnd());
      send_rx(2'h0, 1'b1);
      set_mode(8'h40);
      chk({8'h0, tx_sel, rx_sel}, 10'h001);
      set_mode(8'h80);
      chk({8'h0, tx_sel, rx_sel}, 10'h002);
      finish_test();
   end
endmodule // uart_config_status_baud_tb
bind ucs_top ucs_top_assertions ucs_top_assertions_i (.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i),
   .bus_req_i(bus_req_i), .rd_data_o(rd_data_o), .rx_pin_i(rx_pin_i), .tx_pin_o(tx_pin_o),
   .rx_serial_sel_o(rx_serial_sel_o), .tx_serial_sel_o(tx_serial_sel_o), .tx_data_i(tx_data_i),
   .tx_write_i(tx_write_i), .tx_ready_o(tx_ready_o), .tx_done_o(tx_done_o),
   .rx_buf_read_i(rx_buf_read_i), .rx_data_o(rx_data_o), .rx_done_o(rx_done_o));
`default_nettype wire
